//--- logic/pll_lock_detect.sv
// pll lock detector, lock pin mux and feedback path with wishbone slave
// assumes edges and comparator level are synchronous to clk (50 MHz)
`timescale 1ns/1ps
module pll_lock_detect
   import pll_lock_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ref_edge,
   input wire logic vco_tick,
   input wire logic lock_pin_comparator,
   output logic irq,
   output logic digital_lock_detect,
   output logic lock_pin_out,
   output logic lock_pin_oe,
   output logic lock_pin_source,
   output logic status_pin,
   output logic reference_watch_pin
);

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic [2:0] reg_prescale;
   logic [7:0] reg_status_sel;
   logic [7:0] reg_lock_ctrl;
   logic [5:0] reg_lock_pin_sel;
   logic [7:0] reg_watch_sel;
   logic [5:0] reg_swallow;
   logic [12:0] reg_main_cnt;
   logic [7:0] reg_delay;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [5:0] idx;
   logic wr_now;
   logic [31:0] next_rdata;
   logic fb_edge;
   logic ref_d;
   logic fb_d;
   logic waiting;
   logic first_ref;
   logic [7:0] span;
   logic meas_done;
   logic [7:0] diff;
   logic [7:0] lock_thr;
   logic [7:0] unlock_thr;
   logic [7:0] need;
   logic [7:0] good_cnt;
   logic detect_off;
   lock_state_t state;
   logic gain_ev;
   logic loss_ev;
   logic [IRQ_W-1:0] events;
   pins_t next_pins;

   // -------------------------------------------------------------
   // functions
   // -------------------------------------------------------------
   // byte-lane merge for a write
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // monitor pin mux, shared by status and reference-watch pins
   function automatic logic mon_pick(input logic [4:0] sel, input logic lock,
                                     input logic cmp);
      logic r;
      r = 1'b0;
      if (sel == MON_DIGITAL) begin
         r = lock;
      end else if (sel == MON_CMP_HIGH) begin
         r = cmp;
      end else if (sel == MON_CMP_LOW) begin
         r = ~cmp;
      end
      return r;
   endfunction : mon_pick

   // -------------------------------------------------------------
   // wishbone slave: ack one cycle after the request, write on ack
   // -------------------------------------------------------------
   assign idx = wb_adr_i[7:2];
   assign wr_now = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;

   // ack pulse; dropped the cycle after it was given
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
      end else if (ce) begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   // read mux; unmapped indices read zero and still ack
   always_comb begin
      next_rdata = 32'h00000000;
      unique case (idx)
         IDX_PRESCALE: next_rdata[2:0] = reg_prescale;
         IDX_STATUS_SEL: next_rdata[7:0] = reg_status_sel;
         IDX_LOCK_CTRL: next_rdata[7:0] = reg_lock_ctrl;
         IDX_LOCK_PIN_SEL: next_rdata[5:0] = reg_lock_pin_sel;
         IDX_WATCH_SEL: next_rdata[7:0] = reg_watch_sel;
         IDX_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
         IDX_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
         IDX_STATE: next_rdata[15:0] = {good_cnt, 7'h00, state == ST_LOCKED};
         IDX_SWALLOW: next_rdata[5:0] = reg_swallow;
         IDX_MAIN_CNT: next_rdata[12:0] = reg_main_cnt;
         IDX_DELAY: next_rdata[7:0] = reg_delay;
         default: next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wb_dat_o <= 32'h00000000;
      end else if (ce && wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         wb_dat_o <= next_rdata;
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_prescale <= RST_REG8[2:0];
         reg_status_sel <= RST_REG8;
         reg_lock_ctrl <= RST_REG8;
         reg_lock_pin_sel <= RST_REG8[5:0];
         reg_watch_sel <= RST_REG8;
         reg_swallow <= RST_REG8[5:0];
         reg_main_cnt <= RST_MAIN_CNT;
         reg_delay <= RST_REG8;
         irq_mask <= RST_REG8[IRQ_W-1:0];
      end else if (ce && wr_now) begin
         unique case (idx)
            IDX_PRESCALE: reg_prescale <= wb_dat_i[2:0];
            IDX_STATUS_SEL: reg_status_sel <= 8'(merge(32'(reg_status_sel), wb_dat_i,
                                                       wb_sel_i));
            IDX_LOCK_CTRL: reg_lock_ctrl <= 8'(merge(32'(reg_lock_ctrl), wb_dat_i,
                                                     wb_sel_i));
            IDX_LOCK_PIN_SEL: reg_lock_pin_sel <= wb_dat_i[5:0];
            IDX_WATCH_SEL: reg_watch_sel <= 8'(merge(32'(reg_watch_sel), wb_dat_i,
                                                     wb_sel_i));
            IDX_SWALLOW: reg_swallow <= wb_dat_i[5:0];
            IDX_MAIN_CNT: reg_main_cnt <= 13'(merge(32'(reg_main_cnt), wb_dat_i,
                                                    wb_sel_i));
            IDX_DELAY: reg_delay <= 8'(merge(32'(reg_delay), wb_dat_i, wb_sel_i));
            IDX_IRQ_MASK: irq_mask <= wb_dat_i[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------
   // edge paths: feedback divider then the two delay cells
   // -------------------------------------------------------------
   fb_divider u_fb_divider (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .vco_tick(vco_tick),
      .cfg('{prescale: reg_prescale, swallow: reg_swallow,
             main_cnt: reg_main_cnt}),
      .fb_edge(fb_edge)
   );

   edge_delay u_ref_delay (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .edge_in(ref_edge),
      .cfg(reg_delay[3:0]),
      .edge_out(ref_d)
   );

   edge_delay u_fb_delay (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .edge_in(fb_edge),
      .cfg(reg_delay[DLY_FB_LO +: 4]),
      .edge_out(fb_d)
   );

   // -------------------------------------------------------------
   // edge time difference, in clocks
   // -------------------------------------------------------------
   // a repeated edge on the same side means the other never came:
   // that counts as a full-scale difference, so a dead input unlocks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         waiting <= 1'b0;
         first_ref <= 1'b0;
         span <= 8'h00;
         meas_done <= 1'b0;
         diff <= 8'h00;
      end else if (ce) begin
         meas_done <= 1'b0;
         if (!waiting) begin
            if (ref_d && fb_d) begin
               meas_done <= 1'b1;
               diff <= 8'h00;
            end else if (ref_d || fb_d) begin
               waiting <= 1'b1;
               first_ref <= ref_d;
               span <= 8'h01;
            end
         end else if (first_ref ? fb_d : ref_d) begin
            meas_done <= 1'b1;
            diff <= span;
            waiting <= 1'b0;
         end else if (first_ref ? ref_d : fb_d) begin
            meas_done <= 1'b1;
            diff <= DIFF_MAX;
            span <= 8'h01;
         end else if (span != DIFF_MAX) begin
            span <= span + 8'h01;
         end
      end
   end

   // thresholds; high range (bit clear) doubles the window
   always_comb begin
      unique case (reg_status_sel[1:0])
         2'h0: lock_thr = THR_ABP0;
         2'h1: lock_thr = THR_ABP1;
         2'h2: lock_thr = THR_ABP2;
         2'h3: lock_thr = THR_ABP3;
      endcase
      if (!reg_lock_ctrl[LOCK_WIN_BIT]) begin
         lock_thr = lock_thr << 1;
      end
      unlock_thr = 8'((lock_thr << 1) + 8'h01); // strictly wider
   end

   // consecutive-cycle count selection
   always_comb begin
      unique case (reg_lock_ctrl[LOCK_CNT_LO +: 2])
         2'h0: need = NEED_SEL0;
         2'h1: need = NEED_SEL1;
         2'h2: need = NEED_SEL2;
         2'h3: need = NEED_SEL3;
      endcase
   end

   assign detect_off = reg_lock_ctrl[LOCK_DIS_BIT];

   // -------------------------------------------------------------
   // lock state machine
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_UNLOCKED;
         good_cnt <= 8'h00;
      end else if (ce) begin
         if (detect_off) begin
            state <= ST_UNLOCKED;
            good_cnt <= 8'h00;
         end else if (meas_done) begin
            unique case (state)
               ST_UNLOCKED: begin
                  if (diff >= lock_thr) begin
                     good_cnt <= 8'h00; // streak broken
                  end else if (good_cnt + 8'h01 >= need) begin
                     state <= ST_LOCKED;
                     good_cnt <= 8'h00;
                  end else begin
                     good_cnt <= good_cnt + 8'h01;
                  end
               end
               ST_LOCKED: begin
                  if (diff > unlock_thr) begin
                     state <= ST_UNLOCKED; // single bad cycle
                  end
               end
            endcase
         end
      end
   end

   assign gain_ev = ce && !detect_off && meas_done && state == ST_UNLOCKED
                    && diff < lock_thr && good_cnt + 8'h01 >= need;
   assign loss_ev = ce && state == ST_LOCKED
                    && (detect_off || (meas_done && diff > unlock_thr));

   always_comb begin
      events = '0;
      events[IRQ_LOCK_GAIN] = gain_ev;
      events[IRQ_LOCK_LOSS] = loss_ev;
   end

   // -------------------------------------------------------------
   // interrupts: sticky, write one to clear, set wins over clear
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_status <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         if (wr_now && idx == IDX_IRQ_STATUS) begin
            irq_status <= (irq_status & ~wb_dat_i[IRQ_W-1:0]) | events;
         end else begin
            irq_status <= irq_status | events;
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // -------------------------------------------------------------
   // pin muxes
   // -------------------------------------------------------------
   // lock pin: open-drain analog modes drive only during phase error,
   // so the external pull sets the idle level
   always_comb begin
      next_pins.lock_out = 1'b0;
      next_pins.lock_oe = 1'b1;
      next_pins.lock_src = 1'b0;
      if (reg_lock_pin_sel == PIN_DIGITAL) begin
         next_pins.lock_out = state == ST_LOCKED;
      end else if (reg_lock_pin_sel == PIN_ANALOG_N) begin
         next_pins.lock_oe = waiting; // low pulses on error
      end else if (reg_lock_pin_sel == PIN_ANALOG_P) begin
         next_pins.lock_out = 1'b1;
         next_pins.lock_oe = waiting; // high pulses on error
      end else if (reg_lock_pin_sel == PIN_CURRENT) begin
         next_pins.lock_src = state == ST_LOCKED;
         next_pins.lock_oe = state != ST_LOCKED; // hard ground
      end
      next_pins.status = mon_pick(reg_status_sel[STATUS_SEL_LO +: 5],
                                  state == ST_LOCKED, lock_pin_comparator);
      next_pins.watch = mon_pick(reg_watch_sel[4:0], state == ST_LOCKED,
                                 lock_pin_comparator);
   end

   // registered pins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lock_pin_out <= 1'b0;
         lock_pin_oe <= 1'b0;
         lock_pin_source <= 1'b0;
         status_pin <= 1'b0;
         reference_watch_pin <= 1'b0;
         digital_lock_detect <= 1'b0;
      end else if (ce) begin
         lock_pin_out <= next_pins.lock_out;
         lock_pin_oe <= next_pins.lock_oe;
         lock_pin_source <= next_pins.lock_src;
         status_pin <= next_pins.status;
         reference_watch_pin <= next_pins.watch;
         digital_lock_detect <= state == ST_LOCKED;
      end
   end
endmodule : pll_lock_detect

//--- logic/pll_lock_pkg.sv
// package of constants and carrier types for the pll lock-detect block
// assumes one 50 MHz clock; register index = byte address / 4
package pll_lock_pkg;

   // -------------------------------------------------------------
   // clock
   // -------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;

   // -------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -------------------------------------------------------------
   localparam logic [5:0] IDX_PRESCALE = 6'h16;
   localparam logic [5:0] IDX_STATUS_SEL = 6'h17;
   localparam logic [5:0] IDX_LOCK_CTRL = 6'h18;
   localparam logic [5:0] IDX_LOCK_PIN_SEL = 6'h1a;
   localparam logic [5:0] IDX_WATCH_SEL = 6'h1b;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
   localparam logic [5:0] IDX_STATE = 6'h22;
   localparam logic [5:0] IDX_SWALLOW = 6'h23;
   localparam logic [5:0] IDX_MAIN_CNT = 6'h24;
   localparam logic [5:0] IDX_DELAY = 6'h25;

   // -------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------
   localparam int LOCK_CNT_LO = 5;
   localparam int LOCK_WIN_BIT = 4;
   localparam int LOCK_DIS_BIT = 3;
   localparam int STATUS_SEL_LO = 2;
   localparam int DLY_FB_LO = 4;
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [12:0] RST_MAIN_CNT = 13'h0003;

   // -------------------------------------------------------------
   // interrupt bits
   // -------------------------------------------------------------
   localparam int IRQ_LOCK_GAIN = 0;
   localparam int IRQ_LOCK_LOSS = 1;
   localparam int IRQ_W = 2;

   // -------------------------------------------------------------
   // lock detector sizing
   // -------------------------------------------------------------
   localparam logic [7:0] DIFF_MAX = 8'hff;
   localparam logic [7:0] NEED_SEL0 = 8'h05;
   localparam logic [7:0] NEED_SEL1 = 8'h10;
   localparam logic [7:0] NEED_SEL2 = 8'h40;
   localparam logic [7:0] NEED_SEL3 = 8'hff;
   localparam logic [7:0] THR_ABP0 = 8'h02;
   localparam logic [7:0] THR_ABP1 = 8'h01;
   localparam logic [7:0] THR_ABP2 = 8'h03;
   localparam logic [7:0] THR_ABP3 = 8'h04;
   localparam logic [12:0] MAIN_BYPASS = 13'h0001;

   // -------------------------------------------------------------
   // pin mux encodings
   // -------------------------------------------------------------
   localparam logic [5:0] PIN_DIGITAL = 6'h00;
   localparam logic [5:0] PIN_ANALOG_N = 6'h01;
   localparam logic [5:0] PIN_ANALOG_P = 6'h02;
   localparam logic [5:0] PIN_CURRENT = 6'h04;
   localparam logic [4:0] MON_LOW = 5'h00;
   localparam logic [4:0] MON_DIGITAL = 5'h01;
   localparam logic [4:0] MON_CMP_HIGH = 5'h02;
   localparam logic [4:0] MON_CMP_LOW = 5'h03;

   // -------------------------------------------------------------
   // prescaler codes: 0..4 two-modulus P=2..32, 5..7 fixed 1..3
   // -------------------------------------------------------------
   localparam logic [2:0] PRE_FIXED_FIRST = 3'h5;

   // -------------------------------------------------------------
   // carrier types
   // -------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic [2:0] code;
   } delay_cfg_t;

   typedef struct packed {
      logic [2:0] prescale;
      logic [5:0] swallow;
      logic [12:0] main_cnt;
   } div_cfg_t;

   typedef struct packed {
      logic lock_out;
      logic lock_oe;
      logic lock_src;
      logic status;
      logic watch;
   } pins_t;

   typedef enum logic [1:0] {
      ST_UNLOCKED = 2'b01,
      ST_LOCKED = 2'b10
   } lock_state_t;

endpackage : pll_lock_pkg

//--- logic/edge_delay.sv
// programmable delay cell on one phase-compare edge path
// assumes edge pulses are one clock wide and synchronous to clk
`timescale 1ns/1ps
module edge_delay
   import pll_lock_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic edge_in,
   input wire delay_cfg_t cfg,
   output logic edge_out
);
   // code 7 reads tap 6, so an eighth stage would never be read
   localparam int TAPS = 7;

   logic [TAPS-1:0] taps;

   // -------------------------------------------------------------
   // tap chain, one clock per code step
   // -------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < TAPS; g++) begin : g_tap
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               taps[g] <= 1'b0;
            end else if (ce) begin
               taps[g] <= (g == 0) ? edge_in : taps[(g == 0) ? 0 : g - 1];
            end
         end
      end
   endgenerate

   // disabled or code zero passes the edge straight through
   always_comb begin
      if (!cfg.en || cfg.code == 3'h0) begin
         edge_out = edge_in;
      end else begin
         edge_out = taps[cfg.code - 3'h1];
      end
   end
endmodule : edge_delay

//--- logic/fb_divider.sv
// feedback divider: prescaler and swallow/main counters as one count
// assumes vco_tick is a one-clock pulse per divided oscillator edge
`timescale 1ns/1ps
module fb_divider
   import pll_lock_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic vco_tick,
   input wire div_cfg_t cfg,
   output logic fb_edge
);
   logic [17:0] total;
   logic [17:0] cnt;
   logic [5:0] ratio;
   logic fixed_mode;

   // prescaler ratio from its code
   always_comb begin
      fixed_mode = cfg.prescale >= PRE_FIXED_FIRST;
      if (fixed_mode) begin
         ratio = 6'(cfg.prescale - PRE_FIXED_FIRST + 3'h1);
      end else begin
         ratio = 6'(6'h2 << cfg.prescale);
      end
   end

   // total count; bypass, fixed and two-modulus forms
   always_comb begin
      if (fixed_mode && cfg.main_cnt == MAIN_BYPASS) begin
         total = 18'(ratio);
      end else if (fixed_mode) begin
         total = 18'(ratio * cfg.main_cnt); // swallow ignored
      end else begin
         total = 18'(ratio * cfg.main_cnt) + 18'(cfg.swallow);
      end
   end

   // -------------------------------------------------------------
   // tick counter; a zero total is treated as one
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 18'h00000;
         fb_edge <= 1'b0;
      end else if (ce) begin
         fb_edge <= 1'b0;
         if (vco_tick) begin
            if (cnt + 18'h00001 >= total) begin
               cnt <= 18'h00000;
               fb_edge <= 1'b1;
            end else begin
               cnt <= cnt + 18'h00001;
            end
         end
      end
   end
endmodule : fb_divider

//--- dv/pll_lock_checker.sv
// checker for bus handshake and lock pin relations of pll_lock_detect
// assumes one clock domain; bound onto the design top below
`timescale 1ns/1ps
module pll_lock_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic ref_edge,
   input wire logic vco_tick,
   input wire logic irq,
   input wire logic digital_lock_detect,
   input wire logic lock_pin_oe,
   input wire logic lock_pin_source
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [7:0] refs;
   logic [7:0] quiet;
   // ------
   // helpers
   // ------
   // ref edges since lock last dropped; saturates so it never wraps
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         refs <= 8'h00;
      end else if (digital_lock_detect) begin
         refs <= 8'h00;
      end else if (ref_edge && refs != 8'hff) begin
         refs <= refs + 8'h01;
      end
   end
   // cycles since any edge or bus answer; lock may only move soon after one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         quiet <= 8'h00;
      end else if (ref_edge || vco_tick || wb_ack_o) begin
         quiet <= 8'h00;
      end else if (quiet != 8'hff) begin
         quiet <= quiet + 8'h01;
      end
   end
   // ------
   // properties
   // ------
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
      else $error("no ack after request");
   ack_pulse_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read bits set");
   lock_count_a: assert property ($rose(digital_lock_detect) |-> refs >= 8'h05)
      else $error("lock before five compares");
   lock_quiet_a: assert property ($changed(digital_lock_detect) |-> quiet < 8'h28)
      else $error("lock moved without a compare");
   source_lock_a: assert property (lock_pin_source |-> digital_lock_detect && !lock_pin_oe)
      else $error("source on while unlocked or grounded");
   reset_unlock_a: assert property ($rose(nrst) |-> !digital_lock_detect && !irq)
      else $error("not unlocked after reset");
   cover property ($rose(digital_lock_detect));
   cover property ($fell(digital_lock_detect));
   cover property (lock_pin_source);
endmodule : pll_lock_checker

bind pll_lock_detect pll_lock_checker chk_u (.clk(clk), .nrst(nrst), .ce(ce),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .ref_edge(ref_edge), .vco_tick(vco_tick), .irq(irq), .lock_pin_oe(lock_pin_oe),
   .digital_lock_detect(digital_lock_detect), .lock_pin_source(lock_pin_source));

//--- dv/pll_lock_detect_tb.sv
// self-checking bench for pll_lock_detect against a lock model
// assumes ce held high and the feedback divider set to ratio one
`timescale 1ns/1ps
module pll_lock_detect_tb;
   import pll_lock_pkg::*;
   logic clk, nrst, ce, wb_cyc_i, wb_stb_i, wb_we_i, ref_edge, vco_tick, lock_pin_comparator;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic wb_ack_o, irq, digital_lock_detect, lock_pin_out, lock_pin_oe, lock_pin_source;
   logic status_pin, reference_watch_pin;
   int err_count, n_checks, seed, lk, cnt, shift;
   int seq [13] = '{0, 1, 0, 6, 0, 1, 0, 0, 0, 6, 8, 0, 15};
   logic [2:0] pexp [5] = '{3'b110, 3'b000, 3'b100, 3'b010, 3'b001};
   pll_lock_detect dut_u (.clk(clk), .nrst(nrst), .ce(ce), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_edge(ref_edge),
      .vco_tick(vco_tick), .lock_pin_comparator(lock_pin_comparator), .irq(irq),
      .digital_lock_detect(digital_lock_detect), .lock_pin_oe(lock_pin_oe),
      .lock_pin_source(lock_pin_source), .status_pin(status_pin), .lock_pin_out(lock_pin_out),
      .reference_watch_pin(reference_watch_pin));
   // ------
   // tasks
   // ------
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   // classic cycle: hold until ack is sampled, then release for a cycle
   task wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= d;
      do begin
         @(posedge clk);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (t >= 20) begin
         err_count++;
         end_sim();
      end
   endtask : wb
   // ref edge, then feedback tick d clocks later; model settles after the gap
   task pair(input int d);
      @(posedge clk);
      ref_edge <= 1'b1;
      vco_tick <= (d == 0);
      for (int k = 1; k <= d; k++) begin
         @(posedge clk);
         ref_edge <= 1'b0;
         vco_tick <= (k == d);
      end
      @(posedge clk);
      ref_edge <= 1'b0;
      vco_tick <= 1'b0;
      repeat (30) @(posedge clk); // compare period far above unlock threshold
      cnt = (d - shift < 3) ? cnt + 1 : 0;
      lk = (d - shift > 8) ? 0 : (lk || cnt >= 5);
      chk(digital_lock_detect, lk);
   endtask : pair
   // ------
   // tests
   // ------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // watchdog sized well above the whole sequence
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_sim();
   end
   initial begin
      {nrst, wb_cyc_i, wb_stb_i, wb_we_i, ref_edge, vco_tick, lock_pin_comparator} = 7'h00;
      {ce, wb_sel_i, wb_adr_i, wb_dat_i} = {1'b1, 4'hf, 8'h00, 32'h0};
      {err_count, n_checks, lk, cnt, shift, seed} = {160'h0, 32'd78245};
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      chk(digital_lock_detect, 0);
      wb(0, IDX_STATE, 0);
      chk(q, 0);
      wb(1, 6'h30, 32'hff);
      wb(0, 6'h30, 0);
      chk(q, 0);
      wb(1, IDX_PRESCALE, 5); // fixed ratio one turns each tick into a feedback edge
      wb(1, IDX_MAIN_CNT, 1); // swallow left at zero
      wb(1, IDX_STATUS_SEL, 8'h04);
      foreach (seq[i]) pair(seq[i]);
      $display("lock sequence test done");
      chk(irq, 0);
      wb(0, IDX_IRQ_STATUS, 0);
      chk(q, 3);
      wb(1, IDX_IRQ_MASK, 3);
      repeat (3) @(posedge clk);
      chk(irq, 1);
      wb(1, IDX_IRQ_STATUS, 3);
      wb(0, IDX_IRQ_STATUS, 0);
      chk(q, 0);
      chk(irq, 0);
      $display("interrupt test done");
      repeat (5) pair(0);
      chk(status_pin, 1);
      foreach (pexp[i]) begin
         wb(1, IDX_LOCK_PIN_SEL, (i == 4) ? 4 : i);
         repeat (3) @(posedge clk);
         chk({lock_pin_out, lock_pin_oe, lock_pin_source}, pexp[i]);
      end
      for (int i = 0; i < 4; i++) begin
         lock_pin_comparator <= 1'($random(seed));
         wb(1, IDX_WATCH_SEL, i);
         repeat (3) @(posedge clk);
         chk(reference_watch_pin, (i == 1) | (i == 2 ? lock_pin_comparator :
             i == 3 ? !lock_pin_comparator : 0));
      end
      pair(15);
      chk({lock_pin_out, lock_pin_oe, lock_pin_source}, 3'b010);
      $display("pin mux test done");
      wb(1, IDX_DELAY, 8'h0f);
      shift = 7;
      repeat (5) pair(7);
      $display("delay cell test done");
      end_sim();
   end
endmodule : pll_lock_detect_tb
